// File: core/flash_host_ctrl.sv
// Host controller that drives a byte-wide command-sequenced flash by its pins.
// Assumes the board switches the elevated reset level on id_high_voltage_en_o.
// What this block does
// - Write needs CE, WE low, OE high
// - Autoselect persists until reset written
// - Timeout bit high needs reset command
// - Program is four writes, in fixed order
// - Chip erase is six writes
// - Unlock AA/555, 55/2AA and command bytes
`timescale 1ns/1ps
`include "flash_ctrl_params.svh"

module flash_host_ctrl #(
  parameter logic [31:0] POLL_LIMIT = 32'(`FL_POLL_LIMIT)
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  // User command
  input  wire logic              cmd_valid_i,
  output logic                   cmd_ready_o,
  input  wire flash_ctrl_pkg::op_t cmd_op_i,
  input  wire logic [17:0]       cmd_addr_i,
  input  wire logic [7:0]        cmd_data_i,
  // User response
  output logic                   rsp_valid_o,
  output logic [7:0]             rsp_data_o,
  output logic                   rsp_err_o,
  // Board levels
  input  wire logic              unprotect_req_i,
  input  wire logic              supply_lockout_level_i,
  output logic                   id_high_voltage_en_o,
  // Flash pins
  output logic [17:0]            fl_addr_o,
  output logic [7:0]             dq_o,
  output logic                   dq_oe_o,
  input  wire logic [7:0]        dq_i,
  output logic                   ce_n_o,
  output logic                   we_n_o,
  output logic                   oe_n_o,
  output logic                   reset_n_o
);
  import flash_ctrl_pkg::*;

  seq_state_t  state;
  op_t         op;
  logic [17:0] op_addr;
  logic [7:0]  op_data;
  logic [2:0]  idx;
  logic        abort;
  logic        issued;
  logic        err;
  logic [7:0]  first_rd;
  logic [31:0] poll_cnt;
  logic [7:0]  hw_cnt;
  logic        hw_release;
  logic        lko_meta;
  logic        lko_sync;
  logic        bus_start;
  logic        bus_write;
  logic [25:0] bus_word;
  logic        bus_done;
  logic [7:0]  bus_rd;

  // --------------------------------------------------------------------------
  // Write step table
  // --------------------------------------------------------------------------
  function automatic logic [25:0] seq_step(input op_t o, input logic [2:0] i,
                                           input logic [17:0] a, input logic [7:0] d);
    logic [25:0] w;
    w = {`FL_ZERO_ADDR, `FL_CMD_RESET};
    if (o != OP_RESET) begin
      case (i)
        3'd0: w = {`FL_UNLOCK1_ADDR, `FL_UNLOCK1_BYTE};
        3'd1: w = {`FL_UNLOCK2_ADDR, `FL_UNLOCK2_BYTE};
        3'd2: w = (o == OP_PROGRAM) ? {`FL_UNLOCK1_ADDR, `FL_CMD_PROGRAM} :
                  (o == OP_CHIP_ERASE) ? {`FL_UNLOCK1_ADDR, `FL_CMD_ERASE_SET} :
                  {`FL_UNLOCK1_ADDR, `FL_CMD_AUTOSEL};
        3'd3: w = (o == OP_PROGRAM) ? {a, d} :
                  (o == OP_CHIP_ERASE) ? {`FL_UNLOCK1_ADDR, `FL_UNLOCK1_BYTE} : w;
        3'd4: w = {`FL_UNLOCK2_ADDR, `FL_UNLOCK2_BYTE};
        3'd5: w = {`FL_UNLOCK1_ADDR, `FL_CMD_CHIP_ERASE};
        default: w = {`FL_ZERO_ADDR, `FL_CMD_RESET};
      endcase
    end
    return w;
  endfunction

  // --------------------------------------------------------------------------
  // Bus request
  // --------------------------------------------------------------------------
  assign bus_start  = ((state == ST_WRITE) || (state == ST_READ) || (state == ST_POLL1) ||
                       (state == ST_POLL2) || (state == ST_VERIFY)) && !issued;
  assign bus_write  = (state == ST_WRITE);
  assign bus_word   = (state != ST_WRITE) ? {op_addr, 8'h00} :
                      abort ? {`FL_ZERO_ADDR, `FL_CMD_RESET} :
                      seq_step(op, idx, op_addr, op_data);

  // Lockout stalls new work; the device resets itself meanwhile.
  assign cmd_ready_o = (state == ST_IDLE) && !lko_sync;

  // --------------------------------------------------------------------------
  // Board level synchroniser and unprotect request
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    lko_meta <= supply_lockout_level_i;
    lko_sync <= lko_meta;
  end

  // Only switched between operations so no sequence sees the level change.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      id_high_voltage_en_o <= 1'b0;
    end else if (state == ST_IDLE) begin
      id_high_voltage_en_o <= unprotect_req_i;
    end
  end

  // --------------------------------------------------------------------------
  // Command sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state       <= ST_IDLE;
      op          <= OP_READ;
      op_addr     <= 18'h0_0000;
      op_data     <= 8'h00;
      idx         <= 3'd0;
      abort       <= 1'b0;
      issued      <= 1'b0;
      err         <= 1'b0;
      first_rd    <= 8'h00;
      poll_cnt    <= 32'h0000_0000;
      rsp_valid_o <= 1'b0;
      rsp_data_o  <= 8'h00;
      rsp_err_o   <= 1'b0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (bus_start) begin
        issued <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          if (cmd_valid_i && cmd_ready_o) begin
            op       <= cmd_op_i;
            op_addr  <= cmd_addr_i;
            op_data  <= cmd_data_i;
            idx      <= 3'd0;
            abort    <= 1'b0;
            err      <= 1'b0;
            poll_cnt <= 32'h0000_0000;
            state <= (cmd_op_i == OP_READ) ? ST_READ :
                     (cmd_op_i == OP_HW_RESET) ? ST_HWRST : ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (bus_done) begin
            issued <= 1'b0;
            if (abort || op == OP_RESET) begin
              state <= ST_FIN;
            end else if (op == OP_AUTOSEL && idx >= 3'd2) begin
              // Reset written after the code read leaves autoselect mode.
              state <= (idx == 3'd2) ? ST_READ : ST_FIN;
            end else if ((op == OP_PROGRAM && idx == 3'd3) ||
                         (op == OP_CHIP_ERASE && idx == 3'd5)) begin
              state <= ST_POLL1;
            end else if (lko_sync) begin
              abort <= 1'b1;
              err   <= 1'b1;
              state <= ST_FIN;
            end else begin
              idx <= idx + 3'd1;
            end
          end
        end
        ST_READ: begin
          if (bus_done) begin
            issued     <= 1'b0;
            rsp_data_o <= bus_rd;
            if (op == OP_AUTOSEL) begin
              idx   <= 3'd3;
              state <= ST_WRITE;
            end else begin
              state <= ST_FIN;
            end
          end
        end
        ST_POLL1: begin
          if (bus_done) begin
            issued   <= 1'b0;
            first_rd <= bus_rd;
            state    <= ST_POLL2;
          end
        end
        ST_POLL2: begin
          if (bus_done) begin
            issued <= 1'b0;
            if (bus_rd[`FL_TOGGLE_BIT] == first_rd[`FL_TOGGLE_BIT]) begin
              state <= (op == OP_PROGRAM) ? ST_VERIFY : ST_FIN;
            end else if (bus_rd[`FL_TIMEOUT_BIT] || poll_cnt == POLL_LIMIT) begin
              abort <= 1'b1;
              err   <= 1'b1;
              state <= ST_WRITE;
            end else begin
              poll_cnt <= poll_cnt + 32'h0000_0001;
              state    <= ST_POLL1;
            end
          end
        end
        ST_VERIFY: begin
          if (bus_done) begin
            issued     <= 1'b0;
            rsp_data_o <= bus_rd;
            err        <= (bus_rd != op_data);
            state      <= ST_FIN;
          end
        end
        ST_HWRST: begin
          if (hw_release) begin
            state <= ST_FIN;
          end
        end
        ST_FIN: begin
          rsp_valid_o <= 1'b1;
          rsp_err_o   <= err;
          state       <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Hardware reset pulse
  // --------------------------------------------------------------------------
  // Held low for the minimum pulse, then a recovery gap before the next cycle.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      reset_n_o  <= 1'b1;
      hw_cnt     <= 8'h00;
      hw_release <= 1'b0;
    end else begin
      hw_release <= 1'b0;
      if (state != ST_HWRST) begin
        reset_n_o <= 1'b1;
        hw_cnt    <= 8'h00;
      end else if (hw_release) begin
        hw_cnt <= 8'h00;
      end else if (hw_cnt < 8'(`FL_RP_CYC)) begin
        reset_n_o <= 1'b0;
        hw_cnt    <= hw_cnt + 8'h01;
      end else if (hw_cnt < 8'(`FL_RP_CYC + `FL_RH_CYC)) begin
        reset_n_o <= 1'b1;
        hw_cnt    <= hw_cnt + 8'h01;
      end else begin
        hw_release <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin cycle engine
  // --------------------------------------------------------------------------
  flash_bus_cycle u_bus (
    .mclk_i    (mclk_i),          .nrst_i    (nrst_i),          .start_i   (bus_start),
    .write_i   (bus_write),       .addr_i    (bus_word[25:8]),  .data_i    (bus_word[7:0]),
    .done_o    (bus_done),        .rd_data_o (bus_rd),          .fl_addr_o (fl_addr_o),
    .dq_o      (dq_o),            .dq_oe_o   (dq_oe_o),         .dq_i      (dq_i),
    .ce_n_o    (ce_n_o),          .we_n_o    (we_n_o),          .oe_n_o    (oe_n_o)
  );

endmodule // flash_host_ctrl

// File: core/flash_ctrl_params.svh
// Constants of the flash host controller: command bytes, addresses, timing counts.
// Assumes a 100 MHz controller clock; times are in ns and rounded to cycles here.
`ifndef FLASH_CTRL_PARAMS_SVH
`define FLASH_CTRL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Command sequence addresses and bytes
// ----------------------------------------------------------------------------
`define FL_UNLOCK1_ADDR   18'h0_0555
`define FL_UNLOCK2_ADDR   18'h0_02AA
`define FL_ZERO_ADDR      18'h0_0000
`define FL_UNLOCK1_BYTE   8'hAA
`define FL_UNLOCK2_BYTE   8'h55
`define FL_CMD_AUTOSEL    8'h90
`define FL_CMD_PROGRAM    8'hA0
`define FL_CMD_ERASE_SET  8'h80
`define FL_CMD_CHIP_ERASE 8'h10
`define FL_CMD_RESET      8'hF0

// ----------------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------------
`define FL_TOGGLE_BIT     6
`define FL_TIMEOUT_BIT    5

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define FL_CLK_MHZ        100
`define FL_T_CS_NS        10
`define FL_T_WP_NS        35
`define FL_T_WPH_NS       20
`define FL_T_ACC_NS       120
`define FL_T_RP_NS        500
`define FL_T_RH_NS        50
`define FL_CS_CYC   ((`FL_T_CS_NS * `FL_CLK_MHZ + 999) / 1000)
`define FL_WP_CYC   ((`FL_T_WP_NS * `FL_CLK_MHZ + 999) / 1000)
`define FL_WPH_CYC  ((`FL_T_WPH_NS * `FL_CLK_MHZ + 999) / 1000)
`define FL_ACC_CYC  ((`FL_T_ACC_NS * `FL_CLK_MHZ + 999) / 1000)
`define FL_RP_CYC   ((`FL_T_RP_NS * `FL_CLK_MHZ + 999) / 1000)
`define FL_RH_CYC   ((`FL_T_RH_NS * `FL_CLK_MHZ + 999) / 1000)
`define FL_SYNC_CYC 2
`define FL_POLL_LIMIT 2000000

`endif

// File: core/flash_ctrl_pkg.sv
// Types shared by the flash host controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_ctrl_pkg;

  // --------------------------------------------------------------------------
  // User operations
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_READ       = 3'b000,
    OP_RESET      = 3'b001,
    OP_PROGRAM    = 3'b010,
    OP_CHIP_ERASE = 3'b011,
    OP_AUTOSEL    = 3'b100,
    OP_HW_RESET   = 3'b101
  } op_t;

  // --------------------------------------------------------------------------
  // Sequencer and bus cycle states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_WRITE  = 3'b001,
    ST_READ   = 3'b010,
    ST_POLL1  = 3'b011,
    ST_POLL2  = 3'b100,
    ST_VERIFY = 3'b101,
    ST_HWRST  = 3'b110,
    ST_FIN    = 3'b111
  } seq_state_t;

  typedef enum logic [1:0] {
    BS_IDLE  = 2'b00,
    BS_SETUP = 2'b01,
    BS_PULSE = 2'b10,
    BS_HOLD  = 2'b11
  } bus_state_t;

endpackage

// File: core/flash_bus_cycle.sv
// One strobed read or write cycle on the flash pins.
// Assumes start_i is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
`include "flash_ctrl_params.svh"

module flash_bus_cycle (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  // Request
  input  wire logic        start_i,
  input  wire logic        write_i,
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  data_i,
  output logic             done_o,
  output logic [7:0]       rd_data_o,
  // Flash pins
  output logic [17:0]      fl_addr_o,
  output logic [7:0]       dq_o,
  output logic             dq_oe_o,
  input  wire logic [7:0]  dq_i,
  output logic             ce_n_o,
  output logic             we_n_o,
  output logic             oe_n_o
);
  import flash_ctrl_pkg::*;

  bus_state_t  bstate;
  logic        is_write;
  logic [7:0]  cnt;
  logic [7:0]  dq_meta;
  logic [7:0]  dq_sync;

  // --------------------------------------------------------------------------
  // Data input synchroniser
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    dq_meta <= dq_i;
    dq_sync <= dq_meta;
  end

  // --------------------------------------------------------------------------
  // Cycle sequencer
  // --------------------------------------------------------------------------
  // Address is set as CE falls, before WE or OE falls, and held past their rise, so the
  // later falling edge and the earlier rising edge both see stable values.
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      bstate    <= BS_IDLE;
      is_write  <= 1'b0;
      cnt       <= 8'h00;
      done_o    <= 1'b0;
      rd_data_o <= 8'h00;
      fl_addr_o <= 18'h0_0000;
      dq_o      <= 8'h00;
      dq_oe_o   <= 1'b0;
      ce_n_o    <= 1'b1;
      we_n_o    <= 1'b1;
      oe_n_o    <= 1'b1;
    end else begin
      done_o <= 1'b0;
      case (bstate)
        BS_IDLE: begin
          if (start_i) begin
            is_write  <= write_i;
            fl_addr_o <= addr_i;
            dq_o      <= data_i;
            dq_oe_o   <= write_i;
            ce_n_o    <= 1'b0;
            oe_n_o    <= 1'b1;
            cnt       <= 8'(`FL_CS_CYC);
            bstate    <= BS_SETUP;
          end
        end
        BS_SETUP: begin
          if (cnt <= 8'h01) begin
            if (is_write) begin
              we_n_o <= 1'b0;
              cnt    <= 8'(`FL_WP_CYC);
            end else begin
              oe_n_o <= 1'b0;
              cnt    <= 8'(`FL_ACC_CYC + `FL_SYNC_CYC);
            end
            bstate <= BS_PULSE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        BS_PULSE: begin
          if (cnt <= 8'h01) begin
            if (!is_write) begin
              rd_data_o <= dq_sync;
            end
            we_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            ce_n_o <= 1'b1;
            cnt    <= 8'(`FL_WPH_CYC);
            bstate <= BS_HOLD;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        BS_HOLD: begin
          if (cnt <= 8'h01) begin
            dq_oe_o <= 1'b0;
            done_o  <= 1'b1;
            bstate  <= BS_IDLE;
          end else begin
            cnt <= cnt - 8'h01;
          end
        end
        default: begin
          bstate <= BS_IDLE;
        end
      endcase
    end
  end

endmodule // flash_bus_cycle

// File: dv/flash_dev_model.sv
// Behavioural byte-wide flash that answers the host controller pins.
// Assumes the bench resolves the shared data bus from the host's dq_oe_o alone.
`timescale 1ns/1ps

module flash_dev_model #(
  parameter logic [7:0] MFR_CODE = 8'h5C,  // Arbitrary identity value
  parameter logic [7:0] DEV_CODE = 8'hC3   // Arbitrary identity value
) (
  input  wire logic [17:0] addr_i,
  input  wire logic [7:0]  dq_i,
  output logic [7:0]       dq_o,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        reset_n_i,
  input  wire logic        id_hv_i,
  input  wire logic        lockout_i,
  input  wire logic        tmo_i
);
  logic [7:0]  mem [int];
  logic [7:0]  tmp [int];
  logic [7:0]  rd = 8'h00;
  logic [7:0]  pd = 8'h00;
  logic [17:0] la = '0;
  logic        tog = 1'b0;
  logic        er = 1'b0;
  logic        pu_block = 1'b0;
  int          st = 0;
  realtime     t_f = 0;
  realtime     t_done = 0;
  wire         wr_n = ce_n_i | we_n_i;

  function automatic logic prot(int a);
    return a[17:16] == 2'b11;
  endfunction
  function automatic logic [7:0] arr(int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // Released bus shows the inverse, never a stale copy
  assign dq_o = (!ce_n_i && !oe_n_i && reset_n_i) ? rd : ~rd;

  initial #0 pu_block = (ce_n_i === 1'b0) && (we_n_i === 1'b0) && (oe_n_i === 1'b1);

  always @(negedge wr_n) begin
    t_f = $realtime;
    la  = addr_i;
  end

  always @(posedge wr_n) begin
    // Short pulses, read strobe low and lockout all block the write
    if (pu_block) pu_block = 1'b0;
    else if (oe_n_i && reset_n_i && !lockout_i && $realtime - t_f >= 5) begin
      if (dq_i == 8'hF0 && st != 8) st = 0;
      else case (st)
        0: st = (la == 18'h0_0555 && dq_i == 8'hAA) ? 1 : 0;
        1: st = (la == 18'h0_02AA && dq_i == 8'h55) ? 2 : 0;
        2: st = la != 18'h0_0555 ? 0 : dq_i == 8'h90 ? 7 : dq_i == 8'hA0 ? 3 :
                dq_i == 8'h80 ? 4 : 0;
        3: begin
          if (prot(la) && !id_hv_i) st = 0;
          else begin
            pd = dq_i;
            er = 0;
            if (!tmo_i) mem[la] = arr(la) & dq_i;
            st = tmo_i ? 9 : 8;
            t_done = $realtime + 1000;
          end
        end
        4: st = (la == 18'h0_0555 && dq_i == 8'hAA) ? 5 : 0;
        5: st = (la == 18'h0_02AA && dq_i == 8'h55) ? 6 : 0;
        6: begin
          if (la == 18'h0_0555 && dq_i == 8'h10) begin
            tmp = mem;
            mem.delete();
            foreach (tmp[k]) if (prot(k) && !id_hv_i) mem[k] = tmp[k];
            pd = 8'h00;
            er = 1;
            st = 8;
            t_done = $realtime + 1500;
          end else st = 0;
        end
        7: st = 7;
        default: st = st;
      endcase
    end
  end

  always @(negedge oe_n_i) begin
    if (!ce_n_i) begin
      tog = ~tog;
      if (st >= 8) rd = {~pd[7], tog, st == 9, 2'b00, er & tog, 2'b00};
      else if (st == 7) rd = addr_i[7:0] == 8'h00 ? MFR_CODE : addr_i[7:0] == 8'h01 ?
          DEV_CODE : addr_i[7:0] == 8'h02 ? {7'h0, prot(addr_i)} : arr(addr_i);
      else rd = arr(addr_i);
    end
  end

  always #10 if (st == 8 && $realtime >= t_done) st = 0;
  always @(negedge reset_n_i or posedge lockout_i) st = 0;
endmodule // flash_dev_model

// File: dv/flash_host_ctrl_asserts.sv
// Port-level checks of the flash host controller pin sequencing.
// Assumes it is bound into every flash_host_ctrl instance.
`timescale 1ns/1ps

module flash_host_ctrl_asserts #(
  parameter logic [31:0] POLL_LIMIT = 32'd16
) (
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        cmd_ready_o,
  input wire logic        rsp_valid_o,
  input wire logic        rsp_err_o,
  input wire logic        unprotect_req_i,
  input wire logic        supply_lockout_level_i,
  input wire logic        id_high_voltage_en_o,
  input wire logic [17:0] fl_addr_o,
  input wire logic [7:0]  dq_o,
  input wire logic        dq_oe_o,
  input wire logic        ce_n_o,
  input wire logic        we_n_o,
  input wire logic        oe_n_o,
  input wire logic        reset_n_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  a_write_oe_high: assert property (!we_n_o |-> oe_n_o && !ce_n_o)
    else $error("write strobe without chip select or with read strobe");
  a_read_no_drive: assert property (!oe_n_o |-> !dq_oe_o)
    else $error("host drives data while reading");
  a_we_pulse_len: assert property ($fell(we_n_o) |-> !we_n_o [*4])
    else $error("write pulse too short");
  a_addr_stable_we: assert property (!we_n_o |-> $stable(fl_addr_o))
    else $error("address moved during write pulse");
  a_data_held_we: assert property ($rose(we_n_o) |-> dq_oe_o && $stable(dq_o))
    else $error("data not held at write pulse end");
  a_lockout_blocks: assert property (supply_lockout_level_i [*3] |-> !cmd_ready_o)
    else $error("command accepted under supply lockout");
  a_hv_follows_req: assert property ($changed(id_high_voltage_en_o) |->
    id_high_voltage_en_o == $past(unprotect_req_i))
    else $error("elevated level enable not copied from request");
  a_reset_pulse_len: assert property ($fell(reset_n_o) |-> !reset_n_o [*8])
    else $error("reset pin pulse too short");

  c_err_rsp: cover property (rsp_valid_o && rsp_err_o);
  c_ok_rsp: cover property (rsp_valid_o && !rsp_err_o);
  c_hw_reset: cover property ($fell(reset_n_o));
endmodule // flash_host_ctrl_asserts

bind flash_host_ctrl flash_host_ctrl_asserts #(.POLL_LIMIT(POLL_LIMIT)) i_flash_host_ctrl_asserts (
  .mclk_i(mclk_i), .nrst_i(nrst_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
  .rsp_err_o(rsp_err_o), .unprotect_req_i(unprotect_req_i),
  .supply_lockout_level_i(supply_lockout_level_i), .id_high_voltage_en_o(id_high_voltage_en_o),
  .fl_addr_o(fl_addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
  .oe_n_o(oe_n_o), .reset_n_o(reset_n_o));

// File: dv/flash_host_ctrl_tb_top.sv
// Self-checking bench: controller against the behavioural flash.
// Assumes a shortened poll limit so timeouts end quickly.
`timescale 1ns/1ps

module flash_host_ctrl_tb_top;
  import flash_ctrl_pkg::*;
  logic        mclk_i = 0, nrst_i = 0, cmd_valid_i = 0, unprotect_req_i = 0;
  logic        supply_lockout_level_i = 0, tmo = 0;
  op_t         cmd_op_i = OP_READ;
  logic [17:0] cmd_addr_i = '0, fl_addr_o, a;
  logic [7:0]  cmd_data_i = '0, rsp_data_o, dq_o, dev_dq, rd, d;
  logic        cmd_ready_o, rsp_valid_o, rsp_err_o, id_high_voltage_en_o;
  logic        dq_oe_o, ce_n_o, we_n_o, oe_n_o, reset_n_o, err;
  wire  [7:0]  bus = dq_oe_o ? dq_o : dev_dq;
  int          seed = 61836, mismatches = 0, tests_run = 0;
  logic [7:0]  ref_mem [int];
  logic [17:0] as_a [4] = '{18'h2_AB00, 18'h1_0001, 18'h3_0002, 18'h0_5502};
  logic [7:0]  as_e [4] = '{8'h5C, 8'hC3, 8'h01, 8'h00};

  always #5 mclk_i = ~mclk_i;

  flash_host_ctrl #(.POLL_LIMIT(32'd16)) i_flash_host_ctrl (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .rsp_err_o(rsp_err_o),
    .unprotect_req_i(unprotect_req_i), .supply_lockout_level_i(supply_lockout_level_i),
    .id_high_voltage_en_o(id_high_voltage_en_o), .fl_addr_o(fl_addr_o), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .dq_i(bus), .ce_n_o(ce_n_o), .we_n_o(we_n_o), .oe_n_o(oe_n_o),
    .reset_n_o(reset_n_o));

  flash_dev_model i_flash_dev_model (
    .addr_i(fl_addr_o), .dq_i(bus), .dq_o(dev_dq), .ce_n_i(ce_n_o), .we_n_i(we_n_o),
    .oe_n_i(oe_n_o), .reset_n_i(reset_n_o), .id_hv_i(id_high_voltage_en_o),
    .lockout_i(supply_lockout_level_i), .tmo_i(tmo));

  function automatic logic [7:0] exp_rd(logic [17:0] x);
    return ref_mem.exists(x) ? ref_mem[x] : 8'hFF;
  endfunction

  task automatic chk8(string nm, logic [7:0] e, logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk1(string nm, logic e, logic s);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", nm, e, s);
    end
  endtask

  // One request, then wait for its single-cycle answer
  task automatic op(op_t o, logic [17:0] x, logic [7:0] y);
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 100) begin
      n++;
      @(negedge mclk_i);
    end
    cmd_op_i = o;
    cmd_addr_i = x;
    cmd_data_i = y;
    cmd_valid_i = 1;
    @(negedge mclk_i);
    cmd_valid_i = 0;
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 20000) begin
      n++;
      @(negedge mclk_i);
    end
    chk1("rsp_valid", 1'b1, rsp_valid_o);
    rd = rsp_data_o;
    err = rsp_err_o;
    @(negedge mclk_i);
  endtask

  task automatic final_report;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #900_000;
    mismatches++;
    final_report;
  end

  initial begin
    repeat (10) @(negedge mclk_i);
    nrst_i = 1;
    op(OP_READ, 18'h0_1234, 8'h00);
    chk8("read_powerup", 8'hFF, rd);
    for (int i = 0; i < 4; i++) begin
      a = {2'b00, 16'($random(seed))};
      d = 8'($random(seed));
      op(OP_PROGRAM, a, d);
      chk1("prog_err", (exp_rd(a) & d) != d, err);
      ref_mem[a] = exp_rd(a) & d;
      op(OP_READ, a, 8'h00);
      chk8("prog_read", exp_rd(a), rd);
    end
    op(OP_PROGRAM, a, 8'hFF);
    chk1("zero_to_one_err", exp_rd(a) != 8'hFF, err);
    chk8("zero_to_one_data", exp_rd(a), rd);
    for (int i = 0; i < 4; i++) begin
      op(OP_AUTOSEL, as_a[i], 8'h00);
      chk8("autosel_code", as_e[i], rd);
    end
    op(OP_READ, a, 8'h00);
    chk8("read_after_autosel", exp_rd(a), rd);
    op(OP_PROGRAM, 18'h3_1000, 8'h5A);
    chk1("prot_refused", 1'b1, err);
    unprotect_req_i = 1;
    repeat (3) @(negedge mclk_i);
    chk1("hv_enable", 1'b1, id_high_voltage_en_o);
    op(OP_PROGRAM, 18'h3_1000, 8'h5A);
    ref_mem[18'h3_1000] = 8'h5A;
    chk1("unprot_prog", 1'b0, err);
    unprotect_req_i = 0;
    repeat (3) @(negedge mclk_i);
    op(OP_PROGRAM, 18'h3_1001, 8'h00);
    chk1("reprotect", 1'b1, err);
    tmo = 1;
    op(OP_PROGRAM, 18'h0_0100, 8'h00);
    chk1("timeout_err", 1'b1, err);
    tmo = 0;
    op(OP_READ, 18'h0_0100, 8'h00);
    chk8("read_after_timeout", exp_rd(18'h0_0100), rd);
    op(OP_CHIP_ERASE, a, 8'h00);
    chk1("erase_err", 1'b0, err);
    op(OP_READ, a, 8'h00);
    chk8("erased_read", 8'hFF, rd);
    op(OP_READ, 18'h3_1000, 8'h00);
    chk8("erase_keeps_prot", 8'h5A, rd);
    op(OP_HW_RESET, 18'h0_0000, 8'h00);
    op(OP_READ, 18'h3_1000, 8'h00);
    chk8("read_after_hw_reset", 8'h5A, rd);
    op(OP_RESET, a, 8'h00);
    chk1("reset_cmd_err", 1'b0, err);
    supply_lockout_level_i = 1;
    repeat (4) @(negedge mclk_i);
    chk1("lockout_ready", 1'b0, cmd_ready_o);
    supply_lockout_level_i = 0;
    repeat (4) @(negedge mclk_i);
    final_report;
  end
endmodule // flash_host_ctrl_tb_top
